/* bench/timer_output_compare_channel_tb.sv */
// Self-checking bench for the channel 4 output-compare block
`timescale 1ns/1ps
`include "tocm_defines.svh"
module timer_output_compare_channel_tb;
   logic ref_clk, rst, psel, penable, pwrite, cnt_down, upd, pol, run;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed, m_rdata;
   logic pready, pslverr, ref_o, pin_o, is_out_o;
   logic [3:0] filt_o;
   logic [1:0] psc_o;
   logic [15:0] cnt, m_mode, m_buf, m_shd;
   logic m_ref, m_pin, m_pmatch, m_pout, m_pfroz;
   int num_errors, cmp_count;

   tocm_channel u_dut (
      .I_REF_CLK(ref_clk),
      .I_RST(rst),
      .I_PSEL(psel),
      .I_PENABLE(penable),
      .I_PWRITE(pwrite),
      .I_PADDR(paddr),
      .I_PWDATA(pwdata),
      .O_PRDATA(prdata),
      .O_PREADY(pready),
      .O_PSLVERR(pslverr),
      .I_COUNTER_VALUE(cnt),
      .I_COUNT_DOWN(cnt_down),
      .I_UPDATE_EVENT(upd),
      .I_CH4_OUTPUT_POLARITY(pol),
      .O_CH4_REFERENCE_SIGNAL(ref_o),
      .O_CH4_PIN_OUTPUT(pin_o),
      .O_CH4_IS_OUTPUT(is_out_o),
      .O_CH4_CAPTURE_FILTER(filt_o),
      .O_CH4_CAPTURE_PRESCALE(psc_o)
   );

   // Xorshift source, seeded with 2
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task stop_test;
      if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // One APB transfer; entered just after a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      chk("pready", pready, 1'b1);
      chk("pslverr", pslverr, !(a inside {`TOCM_MODE_CTRL_ADDR,
         `TOCM_CMP_ADDR, `TOCM_STATUS_ADDR}));
      if (!w) chk("prdata", prdata, m_rdata);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Reference model; reads pre-edge values, like the registers it mirrors
   always @(posedge ref_clk) begin : model
      logic is_o, be, eq, oc, nref;
      logic [2:0] md;
      if (rst) begin
         {m_mode, m_buf, m_shd, m_rdata} <= '0;
         {m_ref, m_pin, m_pmatch, m_pout} <= '0;
         m_pfroz <= 1'b1;
      end else begin
         md = m_mode[14:12];
         is_o = m_mode[9:8] == 2'h0;
         be = m_mode[11] & is_o;
         eq = cnt == m_shd;
         oc = cnt_down ? !(cnt > m_shd) : (cnt < m_shd);
         nref = m_ref;
         if (is_o) case (md)
            3'h1: if (eq) nref = 1'b1;
            3'h2: if (eq) nref = 1'b0;
            3'h3: if (eq && !m_pmatch) nref = !m_ref;
            3'h4: nref = 1'b0;
            3'h5: nref = 1'b1;
            3'h6, 3'h7: if (oc != m_pout || m_pfroz) begin
               nref = (md == 3'h6) ? oc : !oc;
            end
            default: ;
         endcase
         m_ref <= nref;
         m_pin <= nref ^ pol;
         m_pmatch <= eq;
         m_pout <= oc;
         m_pfroz <= (md == 3'h0) || !is_o;
         if (upd && be) m_shd <= m_buf;
         if (psel && penable && pwrite) begin
            if (paddr == `TOCM_MODE_CTRL_ADDR) m_mode <= pwdata[15:0];
            if (paddr == `TOCM_CMP_ADDR) begin
               m_buf <= pwdata[15:0];
               if (!be) m_shd <= pwdata[15:0];
            end
         end
         if (psel && !penable && !pwrite) case (paddr)
            `TOCM_MODE_CTRL_ADDR: m_rdata <= {16'h0000, m_mode};
            `TOCM_CMP_ADDR: m_rdata <= {16'h0000, be ? m_buf : m_shd};
            `TOCM_STATUS_ADDR: m_rdata <= {m_shd, 14'h0000, is_o, m_ref};
            default: m_rdata <= 32'h00000000;
         endcase
      end
   end

   // Timer-side inputs; small counter range so matches are frequent
   always @(posedge ref_clk) begin : stim
      logic [31:0] r;
      if (run) begin
         r = rnd();
         cnt <= {12'h000, r[3:0]};
         cnt_down <= r[4];
         upd <= r[7:5] == 3'h0;
         pol <= r[8];
      end
   end

   // Channel outputs against the model every cycle
   always @(negedge ref_clk) begin : check
      logic in_m;
      in_m = m_mode[9:8] != 2'h0;
      if (run && !rst) begin
         chk("ref", ref_o, m_ref);
         if (m_mode[14]) begin
            chk("ref_hi", ref_o, m_ref);
         end
         chk("pin", pin_o, m_pin);
         chk("is_out", is_out_o, m_mode[9:8] == 2'h0);
         chk("filter", filt_o, in_m ? m_mode[15:12] : 4'h0);
         chk("prescale", psc_o, in_m ? m_mode[11:10] : 2'h0);
      end
   end

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Hang guard, far beyond the roughly 1140 cycles of the run
   initial begin
      #2500000;
      num_errors++;
      stop_test;
   end

   initial begin : main
      logic [31:0] r;
      {psel, penable, pwrite, cnt_down, upd, pol, run} = '0;
      {paddr, pwdata, cnt} = '0;
      {num_errors, cmp_count} = '0;
      seed = 32'h00000002;
      rst = 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      run <= 1'b1;
      apb(1'b0, `TOCM_MODE_CTRL_ADDR, 32'h0);
      apb(1'b0, `TOCM_CMP_ADDR, 32'h0);
      apb(1'b0, `TOCM_STATUS_ADDR, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      // Every compare mode buffered, modes below PWM1 also unbuffered; frozen between modes
      for (int m = 0; m < 8; m++) begin
         for (int b = 0; b < 2; b++) begin
            if (m >= 6 && b == 0) continue;
            apb(1'b1, `TOCM_MODE_CTRL_ADDR,
               {16'h0000, 1'b0, m[2:0], b[0], 11'h000});
            repeat (4) begin
               apb(1'b1, `TOCM_CMP_ADDR, rnd() & 32'h0000000F);
               repeat (8) @(posedge ref_clk);
               apb(1'b0, `TOCM_CMP_ADDR, 32'h0);
               apb(1'b0, `TOCM_STATUS_ADDR, 32'h0);
            end
            apb(1'b1, `TOCM_MODE_CTRL_ADDR, {20'h00000, b[0], 11'h000});
         end
      end
      // Input directions with random other fields: reference must hold
      for (int d = 1; d < 4; d++) begin
         r = rnd();
         apb(1'b1, `TOCM_MODE_CTRL_ADDR, {16'h0000, r[15:10], d[1:0], r[7:0]});
         repeat (20) @(posedge ref_clk);
         apb(1'b0, `TOCM_MODE_CTRL_ADDR, 32'h0);
      end
      // Unmapped and read-only writes leave everything alone
      apb(1'b1, 12'h100, 32'hFFFFFFFF);
      apb(1'b1, `TOCM_STATUS_ADDR, 32'hFFFFFFFF);
      apb(1'b0, `TOCM_MODE_CTRL_ADDR, 32'h0);
      apb(1'b0, `TOCM_STATUS_ADDR, 32'h0);
      stop_test;
   end
endmodule // timer_output_compare_channel_tb

/* design/tocm_channel.sv */
// Timer channel 4 output-compare logic with APB register slave
`timescale 1ns/1ps
`include "tocm_defines.svh"

// Notes on behaviour
// - Channel direction chosen by direction select
// - Output fields act only when direction zero
// - Capture fields act only when direction nonzero
// - Reference active high, pin follows polarity
// - Frozen mode: matches leave outputs alone
// - Mode 001 drives reference high on match
// - Mode 010 drives reference low on match
// - Mode 011 toggles reference on each match
// - Modes 100/101 force reference low/high
// - PWM1: active below compare, counting up
// - PWM2: inverse of PWM1 levels
// - PWM level moves on outcome change or on entry from frozen
// - Unbuffered writes reach shadow at once
// - Buffered reads and writes use buffer register
// - Buffer loads shadow on every update event while buffered
module tocm_channel (
   input wire logic I_REF_CLK,
   input wire logic I_RST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [`TOCM_ADDR_W-1:0] I_PADDR,
   input wire logic [`TOCM_DATA_W-1:0] I_PWDATA,
   output logic [`TOCM_DATA_W-1:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire logic [`TOCM_CNT_W-1:0] I_COUNTER_VALUE,
   input wire logic I_COUNT_DOWN,
   input wire logic I_UPDATE_EVENT,
   input wire logic I_CH4_OUTPUT_POLARITY,
   output logic O_CH4_REFERENCE_SIGNAL,
   output logic O_CH4_PIN_OUTPUT,
   output logic O_CH4_IS_OUTPUT,
   output logic [`TOCM_FILT_HI-`TOCM_FILT_LO:0] O_CH4_CAPTURE_FILTER,
   output logic [`TOCM_PSC_HI-`TOCM_PSC_LO:0] O_CH4_CAPTURE_PRESCALE
);

   // Register state
   logic [`TOCM_CTRL_HI:0] mode_ctrl_reg;
   logic [`TOCM_DATA_W-1:0] prdata_reg;
   logic ref_reg;
   logic ref_next;
   logic pin_reg;
   logic match_prev_reg;
   logic outcome_prev_reg;
   tocm_pkg::tocm_mode_type prev_mode_reg;

   // Decoded fields
   tocm_pkg::tocm_mode_type mode;
   logic dir_out;
   logic buf_en;
   logic [`TOCM_CNT_W-1:0] buffer_q;
   logic [`TOCM_CNT_W-1:0] shadow_q;
   logic [`TOCM_CNT_W-1:0] shadow_data;
   logic shadow_load;
   logic cmp_equal;
   logic cmp_less;
   logic cmp_greater;
   logic outcome;
   logic pwm_level;
   logic is_pwm;

   // Bus decode
   logic sel_mode;
   logic sel_cmp;
   logic sel_stat;
   logic mapped;
   logic access;
   logic wr_mode;
   logic wr_cmp;
   logic [`TOCM_DATA_W-1:0] rd_mux;

   // Address decode; anything else answers with an error
   assign sel_mode = (I_PADDR == `TOCM_MODE_CTRL_ADDR);
   assign sel_cmp = (I_PADDR == `TOCM_CMP_ADDR);
   assign sel_stat = (I_PADDR == `TOCM_STATUS_ADDR);
   assign mapped = sel_mode | sel_cmp | sel_stat;
   assign access = I_PSEL & I_PENABLE;
   assign wr_mode = access & I_PWRITE & sel_mode;
   assign wr_cmp = access & I_PWRITE & sel_cmp;

   // Zero wait states: read data is captured in the setup cycle
   assign O_PREADY = access;
   assign O_PSLVERR = access & ~mapped;
   assign O_PRDATA = prdata_reg;

   // Field extraction
   assign mode = tocm_pkg::tocm_mode_type'(
      mode_ctrl_reg[`TOCM_MODE_HI:`TOCM_MODE_LO]);
   assign dir_out = (mode_ctrl_reg[`TOCM_DIR_HI:`TOCM_DIR_LO] ==
                     `TOCM_DIR_OUTPUT);
   assign buf_en = mode_ctrl_reg[`TOCM_BUF_BIT] & dir_out;
   assign is_pwm = (mode == tocm_pkg::TOCM_PWM1) |
                   (mode == tocm_pkg::TOCM_PWM2);

   // Capture fields share bits with compare fields, shown only for inputs
   assign O_CH4_CAPTURE_FILTER = dir_out ? '0 :
      mode_ctrl_reg[`TOCM_FILT_HI:`TOCM_FILT_LO];
   assign O_CH4_CAPTURE_PRESCALE = dir_out ? '0 :
      mode_ctrl_reg[`TOCM_PSC_HI:`TOCM_PSC_LO];
   assign O_CH4_IS_OUTPUT = dir_out;
   assign O_CH4_REFERENCE_SIGNAL = ref_reg;
   assign O_CH4_PIN_OUTPUT = pin_reg;

   // Mode register: low half holds channels 3 and 4 fields, rest reads 0
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         mode_ctrl_reg <= `TOCM_MODE_CTRL_RST;
      end else if (wr_mode) begin
         mode_ctrl_reg <= I_PWDATA[`TOCM_CTRL_HI:0];
      end
   end

   // Buffered mode sends the write to the buffer only
   assign shadow_load = (wr_cmp & ~buf_en) |
                        (I_UPDATE_EVENT & buf_en);
   assign shadow_data = buf_en ? buffer_q :
                        I_PWDATA[`TOCM_CNT_W-1:0];

   // Buffer register, always tracks software writes
   tocm_word_reg #(
      .WIDTH(`TOCM_CNT_W),
      .RESET_VALUE(`TOCM_CMP_RST)
   ) u_buffer (
      .i_clk(I_REF_CLK),
      .i_rst(I_RST),
      .i_load(wr_cmp),
      .i_data(I_PWDATA[`TOCM_CNT_W-1:0]),
      .o_q(buffer_q)
   );

   // Active shadow register, the value the comparator uses
   tocm_word_reg #(
      .WIDTH(`TOCM_CNT_W),
      .RESET_VALUE(`TOCM_CMP_RST)
   ) u_shadow (
      .i_clk(I_REF_CLK),
      .i_rst(I_RST),
      .i_load(shadow_load),
      .i_data(shadow_data),
      .o_q(shadow_q)
   );

   // Counter against active compare value
   tocm_compare_unit #(
      .WIDTH(`TOCM_CNT_W)
   ) u_compare (
      .i_count(I_COUNTER_VALUE),
      .i_compare(shadow_q),
      .o_equal(cmp_equal),
      .o_less(cmp_less),
      .o_greater(cmp_greater)
   );

   // PWM1 level; PWM2 is its inverse in both directions
   assign outcome = I_COUNT_DOWN ? ~cmp_greater : cmp_less;
   assign pwm_level = (mode == tocm_pkg::TOCM_PWM2) ?
                      ~outcome : outcome;

   // Read mux; compare reads follow the buffer when it is enabled
   always_comb begin
      rd_mux = '0;
      if (sel_mode) begin
         rd_mux[`TOCM_CTRL_HI:0] = mode_ctrl_reg;
      end else if (sel_cmp) begin
         rd_mux[`TOCM_CNT_W-1:0] = buf_en ? buffer_q : shadow_q;
      end else if (sel_stat) begin
         rd_mux = {shadow_q, `TOCM_STAT_PAD_W'h0, dir_out, ref_reg};
      end
   end

   // Capture read data in setup so the access phase needs no wait
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         prdata_reg <= '0;
      end else if (I_PSEL & ~I_PENABLE & ~I_PWRITE) begin
         prdata_reg <= rd_mux;
      end
   end

   // Reference next level; an input channel freezes it
   always_comb begin
      ref_next = ref_reg;
      if (dir_out) begin
         case (mode)
            tocm_pkg::TOCM_FROZEN: begin
               ref_next = ref_reg;
            end
            tocm_pkg::TOCM_SET: begin
               if (cmp_equal) begin
                  ref_next = 1'h1;
               end
            end
            tocm_pkg::TOCM_CLEAR: begin
               if (cmp_equal) begin
                  ref_next = 1'h0;
               end
            end
            tocm_pkg::TOCM_TOGGLE: begin
               // Edge of match, so a stalled counter toggles once
               if (cmp_equal & ~match_prev_reg) begin
                  ref_next = ~ref_reg;
               end
            end
            tocm_pkg::TOCM_FORCE_LOW: begin
               ref_next = 1'h0;
            end
            tocm_pkg::TOCM_FORCE_HIGH: begin
               ref_next = 1'h1;
            end
            tocm_pkg::TOCM_PWM1,
            tocm_pkg::TOCM_PWM2: begin
               if ((outcome != outcome_prev_reg) |
                   (prev_mode_reg == tocm_pkg::TOCM_FROZEN)) begin
                  ref_next = pwm_level;
               end
            end
            default: begin
               ref_next = ref_reg;
            end
         endcase
      end
   end

   // Reference and pin; polarity high makes the pin active low
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         ref_reg <= 1'h0;
         pin_reg <= 1'h0;
      end else begin
         ref_reg <= ref_next;
         pin_reg <= ref_next ^ I_CH4_OUTPUT_POLARITY;
      end
   end

   // History for match edge, outcome change and mode switch
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         match_prev_reg <= 1'h0;
         outcome_prev_reg <= 1'h0;
         prev_mode_reg <= tocm_pkg::TOCM_FROZEN;
      end else begin
         match_prev_reg <= cmp_equal;
         outcome_prev_reg <= outcome;
         prev_mode_reg <= dir_out ? mode : tocm_pkg::TOCM_FROZEN;
      end
   end

   // Checks on the channel behaviour
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RST);

   sequence s_cmp_write;
      I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR == `TOCM_CMP_ADDR);
   endsequence

   sequence s_pwm_change;
      dir_out && is_pwm && (outcome != outcome_prev_reg);
   endsequence

   sequence s_pwm_steady;
      dir_out && is_pwm && (outcome == outcome_prev_reg) &&
      (prev_mode_reg != tocm_pkg::TOCM_FROZEN);
   endsequence

   a_input_freezes_ref:
   assert property (!dir_out && $stable(mode_ctrl_reg) |=> $stable(ref_reg))
      else $error("Reference moved on an input channel");

   a_capture_field_gate:
   assert property (!dir_out |-> O_CH4_CAPTURE_FILTER ==
      mode_ctrl_reg[`TOCM_FILT_HI:`TOCM_FILT_LO] && !O_CH4_IS_OUTPUT)
      else $error("Capture filter not shown for input channel");

   a_pin_polarity:
   assert property (##1 O_CH4_PIN_OUTPUT ==
      (O_CH4_REFERENCE_SIGNAL ^ $past(I_CH4_OUTPUT_POLARITY)))
      else $error("Pin level does not follow polarity");

   a_frozen_hold:
   assert property (dir_out && mode == tocm_pkg::TOCM_FROZEN
      |=> ref_reg == $past(ref_reg))
      else $error("Frozen mode changed the reference");

   a_set_on_match:
   assert property (dir_out && mode == tocm_pkg::TOCM_SET && cmp_equal
      |=> ref_reg)
      else $error("Reference not set on match");

   a_clear_on_match:
   assert property (dir_out && mode == tocm_pkg::TOCM_CLEAR && cmp_equal
      |=> !ref_reg)
      else $error("Reference not cleared on match");

   a_toggle_on_match:
   assert property (dir_out && mode == tocm_pkg::TOCM_TOGGLE &&
      cmp_equal && !match_prev_reg |=> ref_reg != $past(ref_reg))
      else $error("Reference did not toggle on match");

   a_force_levels:
   assert property (dir_out && (mode == tocm_pkg::TOCM_FORCE_LOW ||
      mode == tocm_pkg::TOCM_FORCE_HIGH) |=> ref_reg == $past(mode[0]))
      else $error("Forced level not applied");

   a_pwm1_level:
   assert property (s_pwm_change ##0 (mode == tocm_pkg::TOCM_PWM1)
      |=> ref_reg == ($past(I_COUNT_DOWN) ? !$past(cmp_greater)
                                          : $past(cmp_less)))
      else $error("PWM1 reference level wrong");

   a_pwm2_level:
   assert property (s_pwm_change ##0 (mode == tocm_pkg::TOCM_PWM2)
      |=> ref_reg == ($past(I_COUNT_DOWN) ? $past(cmp_greater)
                                          : !$past(cmp_less)))
      else $error("PWM2 reference level wrong");

   a_pwm_steady:
   assert property (s_pwm_steady |=> $stable(ref_reg))
      else $error("PWM reference moved without outcome change");

   // Entry from frozen loads the level even with no outcome change
   a_pwm_entry_load:
   assert property (dir_out && is_pwm &&
      prev_mode_reg == tocm_pkg::TOCM_FROZEN |=> ref_reg ==
      ($past(mode[0]) ^ $past(I_COUNT_DOWN ? !cmp_greater : cmp_less)))
      else $error("PWM entry from frozen did not load the level");

   a_direct_write:
   assert property (s_cmp_write ##0 !buf_en
      |=> shadow_q == $past(I_PWDATA[`TOCM_CNT_W-1:0]))
      else $error("Unbuffered write missed the shadow");

   a_buffered_write:
   assert property (s_cmp_write ##0 (buf_en && !I_UPDATE_EVENT)
      |=> $stable(shadow_q) &&
          buffer_q == $past(I_PWDATA[`TOCM_CNT_W-1:0]))
      else $error("Buffered write reached the shadow");

   a_update_load:
   assert property (buf_en && I_UPDATE_EVENT
      |=> shadow_q == $past(buffer_q))
      else $error("Update event did not load the shadow");

endmodule // tocm_channel

/* design/tocm_compare_unit.sv */
// Counter against compare value magnitude comparator
`timescale 1ns/1ps
module tocm_compare_unit #(
   parameter int WIDTH = 16
) (
   input wire logic [WIDTH-1:0] i_count,
   input wire logic [WIDTH-1:0] i_compare,
   output logic o_equal,
   output logic o_less,
   output logic o_greater
);
   // Unsigned compare, both sides same width
   assign o_equal = (i_count == i_compare);
   assign o_less = (i_count < i_compare);
   assign o_greater = (i_count > i_compare);
endmodule // tocm_compare_unit

/* design/tocm_defines.svh */
// Constants for the timer output-compare channel
`ifndef TOCM_DEFINES_SVH
`define TOCM_DEFINES_SVH

// Bus geometry
`define TOCM_ADDR_W 12
`define TOCM_DATA_W 32
`define TOCM_CNT_W 16

// Register byte offsets
`define TOCM_MODE_CTRL_ADDR 12'h01C
`define TOCM_CMP_ADDR 12'h040
`define TOCM_STATUS_ADDR 12'h044

// Reset values
`define TOCM_MODE_CTRL_RST 16'h0000
`define TOCM_CMP_RST 16'h0000

// Mode register fields, channel 4
`define TOCM_CTRL_HI 15
`define TOCM_MODE_HI 14
`define TOCM_MODE_LO 12
`define TOCM_BUF_BIT 11
`define TOCM_DIR_HI 9
`define TOCM_DIR_LO 8
`define TOCM_FILT_HI 15
`define TOCM_FILT_LO 12
`define TOCM_PSC_HI 11
`define TOCM_PSC_LO 10
`define TOCM_DIR_OUTPUT 2'h0

// Status word fields
`define TOCM_STAT_REF_BIT 0
`define TOCM_STAT_DIR_BIT 1
`define TOCM_STAT_PAD_W 14

// Compare mode codes
`define TOCM_OC_FROZEN 3'h0
`define TOCM_OC_SET 3'h1
`define TOCM_OC_CLEAR 3'h2
`define TOCM_OC_TOGGLE 3'h3
`define TOCM_OC_FORCE_LOW 3'h4
`define TOCM_OC_FORCE_HIGH 3'h5
`define TOCM_OC_PWM1 3'h6
`define TOCM_OC_PWM2 3'h7

`endif

/* design/tocm_pkg.sv */
// Types for the timer output-compare channel
`include "tocm_defines.svh"
package tocm_pkg;
   // Compare mode field encoding
   typedef enum logic [2:0] {
      TOCM_FROZEN = `TOCM_OC_FROZEN,
      TOCM_SET = `TOCM_OC_SET,
      TOCM_CLEAR = `TOCM_OC_CLEAR,
      TOCM_TOGGLE = `TOCM_OC_TOGGLE,
      TOCM_FORCE_LOW = `TOCM_OC_FORCE_LOW,
      TOCM_FORCE_HIGH = `TOCM_OC_FORCE_HIGH,
      TOCM_PWM1 = `TOCM_OC_PWM1,
      TOCM_PWM2 = `TOCM_OC_PWM2
   } tocm_mode_type;
endpackage

/* design/tocm_word_reg.sv */
// Loadable word register with synchronous reset
`timescale 1ns/1ps
module tocm_word_reg #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_load,
   input wire logic [WIDTH-1:0] i_data,
   output logic [WIDTH-1:0] o_q
);
   // Holds unless loaded
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_q <= RESET_VALUE;
      end else if (i_load) begin
         o_q <= i_data;
      end
   end
endmodule // tocm_word_reg
